// ---- flash_bus_pkg.sv ----
// package: timing constants, widths and command kinds for the flash bus controller
package flash_bus_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int WIP_W = 3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RANDOM_ACCESS_TIME_NS = 110;
  localparam int PAGE_ACCESS_TIME_NS = 30;
  localparam int WRITE_PULSE_NS = 50;
  localparam int WRITE_RECOVER_NS = 30;
  localparam int INIT_PULSE_WIDTH_NS = 500;
  localparam int RESET_RECOVER_NS = 200;
  localparam int OE_HOLD_NS = 20;
  localparam int BUF_MAX_WORDS = 16;
  localparam int CNT_W = 8;
  // least times round up to whole cycles
  localparam logic [CNT_W-1:0] ACC_CYC =
    CNT_W'((RANDOM_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PACC_CYC =
    CNT_W'((PAGE_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WP_CYC =
    CNT_W'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WR_CYC =
    CNT_W'((WRITE_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RP_CYC =
    CNT_W'((INIT_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RH_CYC =
    CNT_W'((RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OEH_CYC =
    CNT_W'((OE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // data pins pass two sync flops, so a read waits that much longer
  localparam logic [CNT_W-1:0] SYNC_CYC = 8'h02;
  localparam logic [4:0] BUF_MAX = 5'h10;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_INIT} op_type;
endpackage

// ---- flash_req_if.sv ----
// interface: request and answer between the front end and the pin sequencer
`timescale 1ns/10ps
interface flash_req_if;
  import flash_bus_pkg::*;
  logic valid;
  logic ready;
  op_type op;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic keep_sel;
  logic done;
  logic [DATA_W-1:0] rdata;
  modport front (output valid, op, addr, wdata, keep_sel, input ready, done, rdata);
  modport seq (input valid, op, addr, wdata, keep_sel, output ready, done, rdata);
endinterface

// ---- flash_pin_seq.sv ----
// module: drives flash pins for one read, write or reset pulse at a time
`timescale 1ns/10ps
module flash_pin_seq
  import flash_bus_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  flash_req_if.seq req,
  input wire logic [DATA_W-1:0] i_dq_sync,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_reset_n,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_dq_out,
  output logic o_dq_oe
);
  typedef enum logic [2:0] {S_IDLE, S_READ, S_WPULSE, S_WREC, S_RPULSE, S_RREC} st_type;
  st_type st_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [ADDR_W-WIP_W-1:0] page_ff;
  logic page_ok_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic done_ff;

  assign req.ready = (st_ff == S_IDLE);
  assign req.rdata = rdata_ff;
  assign req.done = done_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= S_IDLE;
      cnt_ff <= '0;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_reset_n <= 1'b0;
      o_addr <= '0;
      o_dq_out <= '0;
      o_dq_oe <= 1'b0;
      page_ff <= '0;
      page_ok_ff <= 1'b0;
      rdata_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      o_reset_n <= 1'b1;
      unique case (st_ff)
        S_IDLE: begin
          if (req.valid) begin
            o_addr <= req.addr;
            unique case (req.op)
              OP_READ: begin
                o_ce_n <= 1'b0; // (RL1)
                o_oe_n <= 1'b0; // (RL1)
                o_we_n <= 1'b1;
                o_dq_oe <= 1'b0;
                // full access unless the page is open and select was held (RL5) (RL6)
                // the sync delay is added, else the pins are read before data is valid
                if (page_ok_ff && !o_ce_n && page_ff == req.addr[ADDR_W-1:WIP_W])
                  cnt_ff <= PACC_CYC + SYNC_CYC; // (RL4)
                else
                  cnt_ff <= ACC_CYC + SYNC_CYC;
                page_ff <= req.addr[ADDR_W-1:WIP_W]; // (RL7)
                st_ff <= S_READ;
              end
              OP_WRITE: begin
                o_ce_n <= 1'b0; // (RL8)
                o_oe_n <= 1'b1; // (RL8)
                o_we_n <= 1'b0; // (RL8)
                o_dq_out <= req.wdata;
                o_dq_oe <= 1'b1;
                page_ok_ff <= 1'b0;
                cnt_ff <= WP_CYC;
                st_ff <= S_WPULSE;
              end
              default: begin
                // taken only when idle, so no operation is ever cut short
                o_reset_n <= 1'b0; // (RL22)
                o_ce_n <= 1'b1;
                o_oe_n <= 1'b1;
                o_we_n <= 1'b1;
                o_dq_oe <= 1'b0;
                page_ok_ff <= 1'b0;
                cnt_ff <= RP_CYC;
                st_ff <= S_RPULSE;
              end
            endcase
          end else if (!req.keep_sel) begin
            // releasing select also closes the page
            o_ce_n <= 1'b1;
            o_oe_n <= 1'b1;
            page_ok_ff <= 1'b0;
          end
        end
        S_READ: begin
          if (cnt_ff > 8'h01) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else begin
            rdata_ff <= i_dq_sync;
            done_ff <= 1'b1;
            page_ok_ff <= 1'b1;
            if (!req.keep_sel) begin
              o_ce_n <= 1'b1;
              o_oe_n <= 1'b1;
            end
            st_ff <= S_IDLE;
          end
        end
        S_WPULSE: begin
          if (cnt_ff > 8'h01) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else begin
            o_we_n <= 1'b1;
            o_ce_n <= 1'b1;
            cnt_ff <= WR_CYC;
            st_ff <= S_WREC;
          end
        end
        S_WREC: begin
          if (cnt_ff > 8'h01) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else begin
            o_dq_oe <= 1'b0;
            done_ff <= 1'b1;
            st_ff <= S_IDLE;
          end
        end
        S_RPULSE: begin
          o_reset_n <= 1'b0;
          if (cnt_ff > 8'h01) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else begin
            o_reset_n <= 1'b1;
            cnt_ff <= RH_CYC;
            st_ff <= S_RREC;
          end
        end
        S_RREC: begin
          if (cnt_ff > 8'h01) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else begin
            done_ff <= 1'b1;
            st_ff <= S_IDLE;
          end
        end
      endcase
    end
  end
endmodule // flash_pin_seq

// ---- flash_host_ctrl.sv ----
// module: host-side controller driving a parallel nor flash through its pins
// Function
// (RL1) host reads with select and output gate low, write strobe high
// (RL2) device starts in read-array mode after power-up or reset
// (RL3) device stays in read-array mode until a command write
// (RL4) page is 8 words; upper bits pick page, low three bits pick word
// (RL5) first page access takes full time, later in-page reads take page time
// (RL6) dropping select between accesses forces a full access again
// (RL7) host holds page bits steady and varies only word bits for fast reads
// (RL8) host writes commands with strobe and select low, output gate high
// (RL9) shortened-program mode needs two write cycles per word, not four
// (RL10) erase covers one sector, several sectors or the whole array
// (RL11) buffered programming takes at most 16 words per operation
// (RL12) elevated voltage on protect pin enters shortened, unprotected fast programming
// (RL13) removing elevated voltage restores normal mode and sector protection
// (RL14) host raises protect pin voltage only during accelerated programming
// (RL15) identification mode returns codes on low eight data lines
// (RL16) in standby device outputs float regardless of output gate
// (RL17) leaving standby for a read takes full select access time
// (RL18) deselecting during erase or program does not stop it
// (RL19) stable addresses for access time plus 30 ns enter automatic sleep
// (RL20) sleep keeps last data driven; new address gives data in access time
// (RL21) reset pin low for pulse width aborts, floats outputs, returns to read-array
// (RL22) host reissues any operation a reset interrupted
// (RL23) output gate high floats the device data pins
`timescale 1ns/10ps
module flash_host_ctrl
  import flash_bus_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic [1:0] i_cmd_op,
  input wire logic [ADDR_W-1:0] i_cmd_addr,
  input wire logic [DATA_W-1:0] i_cmd_wdata,
  input wire logic i_cmd_keep_sel,
  input wire logic i_accel_req,
  input wire logic i_buf_start,
  output logic o_rsp_valid,
  output logic [DATA_W-1:0] o_rsp_rdata,
  output logic o_buf_full,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_reset_n,
  output logic o_protect_accel_pin_hv,
  output logic [ADDR_W-1:0] o_addr,
  input wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0] o_dq,
  output logic o_dq_oe
);
  logic rst_s1_ff;
  logic rst_s2_ff;
  logic [DATA_W-1:0] dq_s1_ff;
  logic [DATA_W-1:0] dq_s2_ff;
  logic [4:0] buf_cnt_ff;
  logic accel_ff;
  logic [DATA_W-1:0] rsp_ff;
  logic rsp_v_ff;
  logic write_ok;
  logic wr_take;
  flash_req_if req ();

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  // data pins come from the device, outside this clock
  always_ff @(posedge i_ref_clk or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
    end else begin
      dq_s1_ff <= i_dq;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  // buffered program words counted; the 17th write is held back
  always_ff @(posedge i_ref_clk or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      buf_cnt_ff <= '0;
    end else if (i_buf_start) begin
      // a write taken with the restart is the first word of the new buffer
      buf_cnt_ff <= wr_take ? 5'h01 : 5'h00; // (RL11)
    end else if (wr_take && buf_cnt_ff != BUF_MAX) begin
      buf_cnt_ff <= buf_cnt_ff + 5'h01; // (RL11)
    end
  end

  // accelerate voltage only while no read or reset is in flight
  always_ff @(posedge i_ref_clk or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      accel_ff <= 1'b0;
    end else if (req.ready) begin
      // never raised while the output gate is open for a held read
      accel_ff <= i_accel_req && o_oe_n &&
                  !(i_cmd_valid && op_type'(i_cmd_op) != OP_WRITE); // (RL14)
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      rsp_ff <= '0;
      rsp_v_ff <= 1'b0;
    end else begin
      rsp_v_ff <= req.done;
      if (req.done)
        rsp_ff <= req.rdata;
    end
  end

  assign write_ok = (op_type'(i_cmd_op) != OP_WRITE) || (buf_cnt_ff != BUF_MAX) || i_buf_start;
  assign wr_take = req.valid && req.ready && req.op == OP_WRITE;
  // a read or reset waits until the accelerate voltage has been dropped
  assign req.valid = i_cmd_valid && write_ok && (accel_ff == 1'b0 ||
                     op_type'(i_cmd_op) == OP_WRITE); // (RL14)
  assign req.op = op_type'(i_cmd_op);
  assign req.addr = i_cmd_addr;
  assign req.wdata = i_cmd_wdata;
  assign req.keep_sel = i_cmd_keep_sel;
  assign o_cmd_ready = req.ready && write_ok && (accel_ff == 1'b0 ||
                       op_type'(i_cmd_op) == OP_WRITE);
  assign o_rsp_valid = rsp_v_ff;
  assign o_rsp_rdata = rsp_ff;
  assign o_buf_full = (buf_cnt_ff == BUF_MAX);
  assign o_protect_accel_pin_hv = accel_ff; // (RL12)

  flash_pin_seq u_seq (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_s2_ff),
    .req(req),
    .i_dq_sync(dq_s2_ff),
    .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n),
    .o_we_n(o_we_n),
    .o_reset_n(o_reset_n),
    .o_addr(o_addr),
    .o_dq_out(o_dq),
    .o_dq_oe(o_dq_oe)
  );
endmodule // flash_host_ctrl

// ---- flash_host_ctrl_properties.sv ----
// checker: pin-level properties of the flash host controller
`timescale 1ns/10ps
module flash_host_ctrl_properties
  import flash_bus_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_cmd_op,
  input wire logic i_buf_start,
  input wire logic o_cmd_ready,
  input wire logic o_buf_full,
  input wire logic o_ce_n,
  input wire logic o_oe_n,
  input wire logic o_we_n,
  input wire logic o_reset_n,
  input wire logic o_protect_accel_pin_hv,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic o_dq_oe
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  logic [CNT_W-1:0] low_cnt_ff;
  logic armed_ff;
  // armed only once the pin was seen high, so the power-on pulse is not judged
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      low_cnt_ff <= '0;
      armed_ff <= 1'b0;
    end else begin
      low_cnt_ff <= o_reset_n ? '0 : low_cnt_ff + 1'b1;
      armed_ff <= armed_ff | o_reset_n;
    end
  end
  a_read_strobe_high: assert property (!o_ce_n && !o_oe_n |-> o_we_n)
    else $error("write strobe low during read");
  a_write_gate_high: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
    else $error("bad pin levels during write");
  a_gate_no_drive: assert property (!o_oe_n |-> !o_dq_oe)
    else $error("host drives data while gate low");
  a_hv_refuse: assert property (o_protect_accel_pin_hv && i_cmd_op != 2'h1 |-> !o_cmd_ready)
    else $error("non-program request taken while voltage high");
  a_hv_no_read: assert property (!o_oe_n |-> !o_protect_accel_pin_hv)
    else $error("elevated voltage while output gate open");
  a_buf_refuse: assert property (o_buf_full && !i_buf_start && i_cmd_op == 2'h1 |-> !o_cmd_ready)
    else $error("write taken with buffer full");
  a_reset_quiet: assert property (!o_reset_n |-> o_ce_n && o_we_n && !o_dq_oe)
    else $error("bus active during device reset");
  a_reset_width: assert property (armed_ff && $rose(o_reset_n) |-> low_cnt_ff >= RP_CYC)
    else $error("device reset pulse too short");
  a_page_steady: assert property (!o_ce_n && !o_oe_n && !$past(o_ce_n) && !$past(o_oe_n)
    |-> $stable(o_addr[ADDR_W-1:WIP_W]))
    else $error("page bits changed inside a read");
endmodule // flash_host_ctrl_properties

// ---- flash_dev_model.sv ----
// model: flash device seen from its pins, read-array mode only
`timescale 1ns/10ps
module flash_dev_model
  import flash_bus_pkg::*;
(
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_reset_n,
  input wire logic [ADDR_W-1:0] i_addr,
  output logic [DATA_W-1:0] o_dq,
  output int o_write_cnt
);
  logic [DATA_W-1:0] last;
  time t_full = 0;
  time t_word = 0;
  logic ok = 1'b0;
  wire drive = i_reset_n && !i_ce_n && !i_oe_n && i_we_n;
  // content is a fixed function of the address; commands never alter it here
  wire [DATA_W-1:0] word = i_addr[15:0] ^ 16'h3c5a;
  // a select fall or a new page restarts the full access; a new word only the short one
  always @(negedge i_ce_n or i_addr[ADDR_W-1:WIP_W]) t_full = $time;
  always @(i_addr[WIP_W-1:0]) t_word = $time;
  // polled each ns; one ns of slack keeps a sample right at the access time clean
  always #1 ok = ($time - t_full >= RANDOM_ACCESS_TIME_NS - 1) &&
    ($time - t_word >= PAGE_ACCESS_TIME_NS - 1);
  // released or early bus shows the inverse of the last value, never a lucky match
  assign o_dq = (drive && ok) ? word : ~last;
  always @(word or drive) if (drive) last = word;
  initial o_write_cnt = 0;
  always @(negedge i_we_n) if (i_reset_n) o_write_cnt++;
endmodule // flash_dev_model

// ---- flash_host_ctrl_test.sv ----
// testbench: reads, page reads, buffered writes, acceleration and device reset
`timescale 1ns/10ps
module flash_host_ctrl_test;
  import flash_bus_pkg::*;
  typedef struct {logic rd; logic [DATA_W-1:0] d; int t0; logic fast;} note_type;
  logic i_ref_clk = 1'b0, i_rstn = 1'b0, i_cmd_valid = 1'b0, i_cmd_keep_sel = 1'b0;
  logic i_accel_req = 1'b0, i_buf_start = 1'b0;
  logic [1:0] i_cmd_op = 2'h0;
  logic [ADDR_W-1:0] i_cmd_addr = '0, o_addr;
  logic [DATA_W-1:0] i_cmd_wdata = '0, i_dq, o_dq, o_rsp_rdata, seed = 16'h0037;
  logic o_cmd_ready, o_rsp_valid, o_buf_full, o_ce_n, o_oe_n, o_we_n, o_reset_n;
  logic o_protect_accel_pin_hv, o_dq_oe;
  int cyc = 0, miscompares = 0, n_tests = 0, wr_cnt;
  note_type q[$];
  note_type nt;
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) cyc <= cyc + 1;
  flash_host_ctrl i_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_cmd_valid(i_cmd_valid),
    .o_cmd_ready(o_cmd_ready), .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr),
    .i_cmd_wdata(i_cmd_wdata), .i_cmd_keep_sel(i_cmd_keep_sel), .i_accel_req(i_accel_req),
    .i_buf_start(i_buf_start), .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata),
    .o_buf_full(o_buf_full), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
    .o_reset_n(o_reset_n), .o_protect_accel_pin_hv(o_protect_accel_pin_hv), .o_addr(o_addr),
    .i_dq(i_dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
  flash_dev_model i_dev (.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
    .i_reset_n(o_reset_n), .i_addr(o_addr), .o_dq(i_dq), .o_write_cnt(wr_cnt));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // holds the request until taken, then waits for its answer
  task automatic op(input logic [1:0] k, input logic [23:0] a, input logic ks, input logic f);
    int n;
    n = 0;
    seed = lfsr(seed);
    i_cmd_valid <= 1'b1;
    i_cmd_op <= k;
    i_cmd_addr <= a;
    i_cmd_wdata <= seed;
    i_cmd_keep_sel <= ks;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_cmd_ready !== 1'b1 && n < 300);
    q.push_back('{k == 2'h0, a[15:0] ^ 16'h3c5a, cyc, f});
    i_cmd_valid <= 1'b0;
    @(posedge i_ref_clk);
    n++;
    if (k == 2'h1) chk("wdata", o_dq, seed);
    while (q.size() != 0 && n < 600) begin
      @(posedge i_ref_clk);
      n++;
    end
    // a request never taken or never answered leaves its note behind
    chk("answered", 16'(q.size()), 16'h0);
  endtask
  task automatic refuse(input logic [1:0] k);
    i_cmd_valid <= 1'b1;
    i_cmd_op <= k;
    repeat (5) begin
      @(posedge i_ref_clk);
      chk("ready", 16'(o_cmd_ready), 16'h0);
    end
    i_cmd_valid <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  always @(posedge i_ref_clk) begin
    if (o_rsp_valid === 1'b1 && q.size() != 0) begin
      nt = q.pop_front();
      if (nt.rd) chk("rdata", o_rsp_rdata, nt.d);
      if (nt.rd) chk("fast", 16'(cyc - nt.t0 <= int'(PACC_CYC + SYNC_CYC) + 2),
        16'(nt.fast));
    end
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    for (int i = 0; i < 4; i++) op(2'h0, {8'h00, seed}, 1'b0, 1'b0);
    // keep select over one page: only the first word pays the full access
    for (int i = 0; i < 8; i++) op(2'h0, {21'h0001a5, i[2:0]}, i < 7, i > 0);
    op(2'h0, {21'h0001a5, 3'h3}, 1'b0, 1'b0);
    i_buf_start <= 1'b1;
    @(posedge i_ref_clk);
    i_buf_start <= 1'b0;
    for (int i = 0; i < 16; i++) op(2'h1, {8'h02, seed}, 1'b0, 1'b0);
    chk("buf_full", 16'(o_buf_full), 16'h1);
    chk("writes", 16'(wr_cnt), 16'h10);
    refuse(2'h1);
    // elevated voltage on, buffer restarted for one accelerated word
    i_accel_req <= 1'b1;
    i_buf_start <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    i_buf_start <= 1'b0;
    chk("hv_on", 16'(o_protect_accel_pin_hv), 16'h1);
    op(2'h1, {8'h02, seed}, 1'b0, 1'b0);
    chk("hv_wr", 16'(o_protect_accel_pin_hv), 16'h1);
    // a read is held off until the voltage is down, then runs at full access
    i_cmd_valid <= 1'b1;
    i_cmd_op <= 2'h0;
    @(posedge i_ref_clk);
    chk("hv_wait", 16'(o_cmd_ready), 16'h0);
    op(2'h0, {8'h00, seed}, 1'b0, 1'b0);
    i_accel_req <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    chk("hv_off", 16'(o_protect_accel_pin_hv), 16'h0);
    op(2'h2, 24'h0, 1'b0, 1'b0);
    op(2'h0, {8'h00, seed}, 1'b0, 1'b0);
    summarize();
  end
endmodule // flash_host_ctrl_test
bind flash_host_ctrl flash_host_ctrl_properties i_chk (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
  .i_cmd_op(i_cmd_op), .i_buf_start(i_buf_start), .o_cmd_ready(o_cmd_ready),
  .o_buf_full(o_buf_full), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
  .o_reset_n(o_reset_n), .o_protect_accel_pin_hv(o_protect_accel_pin_hv), .o_addr(o_addr),
  .o_dq_oe(o_dq_oe));
